// ### rtl/flash_status_reg_four_map.vh
// constants for the power, continuous-read and status register four block
// What this block does
// R1: depth bit 0: power-down command B9h enters ultra-deep sleep like 79h, SRAM lost.
// R2: depth bit 1: power-down command B9h enters deep sleep, SRAM kept.
// R3: only ABh wakes from either sleep; a bare chip-select toggle keeps sleeping.
// R4: bit 6 reports sequential program mode; cleared at reset.
// R5: sequential mode: address only on first transfer, later ones reuse kept address.
// R6: bit 5 set whenever a program operation fails; resets to 0.
// R7: bit 4 set whenever an erase operation fails; resets to 0.
// R8: continuous read and quad enable on: after first E7h/EBh, later frames send only quad address/data.
// R9: continuous read or quad enable off: never command-less, opcode every frame.
// R10: bits 2:0 mirror wrap bits of last 77h command; reset value 001.
// R11: depth and continuous-read bits are host writable, readable, reset to 0.
// R12: quad enable on: hold/reset pin becomes data line, its function disabled.
`ifndef FLASH_STATUS_REG_FOUR_MAP_VH
`define FLASH_STATUS_REG_FOUR_MAP_VH
`define OP_PD_SELECT 8'hB9
`define OP_ULTRA_PD 8'h79
`define OP_WAKE 8'hAB
`define OP_WRAP_SET 8'h77
`define OP_QREAD_A 8'hE7
`define OP_QREAD_B 8'hEB
`define OP_SR4_READ 8'h15
`define OP_SR4_WRITE 8'h16
`define SR4_DEPTH_BIT 7
`define SR4_SEQ_BIT 6
`define SR4_PFAULT_BIT 5
`define SR4_EFAULT_BIT 4
`define SR4_CONT_BIT 3
`define WRAP_RESET 3'h1
`define WRAP_BYTE_INDEX 3'h3
`define WRAP_MSB 6
`define WRAP_LSB 4
`endif

// ### rtl/flash_status_reg_four.v
// spi-facing status register four with power-down and continuous-read control
`timescale 1ns/10ps
`default_nettype none
`include "flash_status_reg_four_map.vh"
module flash_status_reg_four (
  input wire ref_clk_in,
  input wire srst_in,
  input wire sclk_in,
  input wire cs_n_in,
  input wire [3:0] io_in,
  output reg [3:0] io_out,
  output reg [3:0] io_oe_out,
  input wire quad_line_enable_in,
  input wire program_fail_in,
  input wire erase_fail_in,
  input wire fault_clear_in,
  input wire seq_prog_enter_in,
  input wire seq_prog_exit_in,
  output reg deep_sleep_out,
  output reg ultra_deep_sleep_out,
  output wire sram_retain_out,
  output wire address_needed_out,
  output wire hold_reset_disabled_out,
  output reg quad_read_start_out,
  output reg continuous_frame_out,
  output reg [7:0] rx_byte_out,
  output reg rx_byte_valid_out
);
  reg sclk_s1, sclk_s2, sclk_s3;
  reg cs_s1, cs_s2, cs_s3;
  reg [3:0] io_s1, io_s2;
  reg power_down_depth_select;
  reg sequential_program_flag;
  reg program_fault_flag;
  reg erase_fault_flag;
  reg continuous_read_enable;
  reg [2:0] burst_wrap_setting;
  reg cont_armed;
  reg quad_mode;
  reg in_data;
  reg [7:0] opcode;
  reg [7:0] shift;
  reg [2:0] bit_cnt;
  reg [2:0] data_cnt;
  reg [7:0] out_shift;
  reg reading;
  wire sclk_rise;
  wire sclk_fall;
  wire frame_start;
  wire frame_end;
  wire asleep;
  wire byte_done;
  wire cont_allowed;
  wire [7:0] next_shift;
  wire [7:0] sr4_value;

  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      io_s1 <= 4'h0;
      io_s2 <= 4'h0;
    end else begin
      sclk_s1 <= sclk_in;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      cs_s1 <= cs_n_in;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      io_s1 <= io_in;
      io_s2 <= io_s1;
    end
  end

  assign sclk_rise = sclk_s2 & ~sclk_s3 & ~cs_s2;
  assign sclk_fall = ~sclk_s2 & sclk_s3 & ~cs_s2;
  assign frame_start = ~cs_s2 & cs_s3;
  assign frame_end = cs_s2 & ~cs_s3;
  assign asleep = deep_sleep_out | ultra_deep_sleep_out;
  assign cont_allowed = continuous_read_enable & quad_line_enable_in; // R9
  assign byte_done = sclk_rise & (quad_mode ? (bit_cnt == 3'h4) : (bit_cnt == 3'h7));
  assign next_shift = quad_mode ? {shift[3:0], io_s2} : {shift[6:0], io_s2[0]};
  assign sr4_value = {power_down_depth_select, sequential_program_flag, program_fault_flag,
                      erase_fault_flag, continuous_read_enable, burst_wrap_setting};
  assign sram_retain_out = deep_sleep_out; // R1 R2
  assign address_needed_out = ~sequential_program_flag; // R5
  assign hold_reset_disabled_out = quad_line_enable_in; // R12

  // frame receiver: opcode always on line 0 unless a command-less frame resumes
  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      quad_mode <= 1'b0;
      in_data <= 1'b0;
      opcode <= 8'h00;
      shift <= 8'h00;
      bit_cnt <= 3'h0;
      data_cnt <= 3'h0;
      cont_armed <= 1'b0;
      quad_read_start_out <= 1'b0;
      continuous_frame_out <= 1'b0;
      rx_byte_out <= 8'h00;
      rx_byte_valid_out <= 1'b0;
    end else begin
      quad_read_start_out <= 1'b0;
      continuous_frame_out <= 1'b0;
      rx_byte_valid_out <= 1'b0;
      if (!cont_allowed) begin
        cont_armed <= 1'b0; // R9
      end
      if (frame_start) begin
        bit_cnt <= 3'h0;
        data_cnt <= 3'h0;
        if (cont_armed && cont_allowed && !asleep) begin
          quad_mode <= 1'b1; // R8
          in_data <= 1'b1;
          continuous_frame_out <= 1'b1;
        end else begin
          quad_mode <= 1'b0;
          in_data <= 1'b0;
          opcode <= 8'h00;
        end
      end else if (sclk_rise) begin
        shift <= next_shift;
        bit_cnt <= byte_done ? 3'h0 : (bit_cnt + (quad_mode ? 3'h4 : 3'h1));
        if (byte_done && !in_data) begin
          opcode <= next_shift;
          in_data <= 1'b1;
          if (!asleep && (next_shift == `OP_QREAD_A || next_shift == `OP_QREAD_B)) begin
            quad_mode <= 1'b1;
            quad_read_start_out <= 1'b1;
            cont_armed <= cont_allowed; // R8
          end else if (!asleep) begin
            cont_armed <= 1'b0;
          end
        end else if (byte_done && !asleep) begin
          rx_byte_out <= next_shift;
          rx_byte_valid_out <= 1'b1;
          if (data_cnt != 3'h7) begin
            data_cnt <= data_cnt + 3'h1;
          end
        end
      end
    end
  end

  // register bits; hardware set beats a same-cycle clear
  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      power_down_depth_select <= 1'b0; // R11
      continuous_read_enable <= 1'b0; // R11
      sequential_program_flag <= 1'b0; // R4
      program_fault_flag <= 1'b0; // R6
      erase_fault_flag <= 1'b0; // R7
      burst_wrap_setting <= `WRAP_RESET; // R10
    end else begin
      if (seq_prog_enter_in) begin
        sequential_program_flag <= 1'b1; // R4
      end else if (seq_prog_exit_in) begin
        sequential_program_flag <= 1'b0;
      end
      if (program_fail_in) begin
        program_fault_flag <= 1'b1; // R6
      end else if (fault_clear_in) begin
        program_fault_flag <= 1'b0;
      end
      if (erase_fail_in) begin
        erase_fault_flag <= 1'b1; // R7
      end else if (fault_clear_in) begin
        erase_fault_flag <= 1'b0;
      end
      if (byte_done && in_data && !asleep && !quad_mode) begin
        if (opcode == `OP_SR4_WRITE && data_cnt == 3'h0) begin
          power_down_depth_select <= next_shift[`SR4_DEPTH_BIT]; // R11
          continuous_read_enable <= next_shift[`SR4_CONT_BIT]; // R11
        end
        if (opcode == `OP_WRAP_SET && data_cnt == `WRAP_BYTE_INDEX) begin
          burst_wrap_setting <= next_shift[`WRAP_MSB:`WRAP_LSB]; // R10
        end
      end
    end
  end

  // power-down commands take effect when chip select rises
  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      deep_sleep_out <= 1'b0;
      ultra_deep_sleep_out <= 1'b0;
    end else if (frame_end && in_data && !quad_mode) begin
      if (asleep) begin
        if (opcode == `OP_WAKE) begin
          deep_sleep_out <= 1'b0; // R3
          ultra_deep_sleep_out <= 1'b0;
        end
      end else if (opcode == `OP_ULTRA_PD) begin
        ultra_deep_sleep_out <= 1'b1; // R1
      end else if (opcode == `OP_PD_SELECT) begin
        deep_sleep_out <= power_down_depth_select; // R2
        ultra_deep_sleep_out <= ~power_down_depth_select; // R1
      end
    end
  end

  // read-back on line 1, shifted on falling clock so the host samples on rising
  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      out_shift <= 8'h00;
      reading <= 1'b0;
      io_out <= 4'h0;
      io_oe_out <= 4'h0;
    end else begin
      if (cs_s2) begin
        reading <= 1'b0;
      end else if (byte_done && !in_data && !asleep && next_shift == `OP_SR4_READ) begin
        reading <= 1'b1;
        out_shift <= sr4_value;
      end else if (sclk_fall && reading) begin
        io_out[1] <= out_shift[7];
        out_shift <= bit_cnt == 3'h7 ? sr4_value : {out_shift[6:0], 1'b0};
      end
      io_oe_out <= {2'b00, reading & ~cs_s2, 1'b0};
      io_out[0] <= 1'b0;
      io_out[3:2] <= 2'b00;
    end
  end
endmodule
`default_nettype wire

// ### bench/flash_status_reg_four_chk.sv
// assertion checker for the status register four block
`timescale 1ns/10ps
`default_nettype none
module flash_status_reg_four_chk (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic cs_n_in,
  input wire logic quad_line_enable_in,
  input wire logic seq_prog_enter_in,
  input wire logic deep_sleep_out,
  input wire logic ultra_deep_sleep_out,
  input wire logic sram_retain_out,
  input wire logic address_needed_out,
  input wire logic hold_reset_disabled_out,
  input wire logic quad_read_start_out,
  input wire logic continuous_frame_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);
  sequence s_enter; seq_prog_enter_in ##1 1'b1; endsequence
  sequence s_awake; !deep_sleep_out && !ultra_deep_sleep_out; endsequence
  property p_ultra; ultra_deep_sleep_out |-> !sram_retain_out && !deep_sleep_out; endproperty
  property p_deep; deep_sleep_out |-> sram_retain_out; endproperty
  property p_stay; (deep_sleep_out || ultra_deep_sleep_out) && !cs_n_in |=> deep_sleep_out || ultra_deep_sleep_out;
  endproperty
  property p_seq; s_enter |-> !address_needed_out; endproperty
  property p_rst; $fell(srst_in) |-> address_needed_out ##0 s_awake; endproperty
  property p_hold; hold_reset_disabled_out == quad_line_enable_in; endproperty
  property p_cont; continuous_frame_out |-> quad_line_enable_in ##0 s_awake; endproperty
  property p_qstart; quad_read_start_out |-> s_awake ##1 !quad_read_start_out; endproperty
  a_ultra: assert property (p_ultra) else $error("ultra sleep keeps buffer");
  a_deep: assert property (p_deep) else $error("deep sleep loses buffer");
  a_stay: assert property (p_stay) else $error("woke with select low");
  a_seq: assert property (p_seq) else $error("sequential mode not shown");
  a_rst: assert property (p_rst) else $error("bad state after reset");
  a_hold: assert property (p_hold) else $error("hold pin function wrong");
  a_cont: assert property (p_cont) else $error("commandless frame not allowed");
  a_qstart: assert property (p_qstart) else $error("quad start pulse wrong");
endmodule
bind flash_status_reg_four flash_status_reg_four_chk chk_u (.ref_clk_in, .srst_in, .cs_n_in, .quad_line_enable_in,
  .seq_prog_enter_in, .deep_sleep_out, .ultra_deep_sleep_out, .sram_retain_out, .address_needed_out,
  .hold_reset_disabled_out, .quad_read_start_out, .continuous_frame_out);
`default_nettype wire

// ### bench/spi_host_model.sv
// behavioural spi host issuing frames
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  input wire logic clk_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic [3:0] io_out,
  input wire logic so_in
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    io_out = 4'h0;
  end
  // clock stands low outside frames; idle lines show inverted data
  task automatic frame(input logic [39:0] d, input int ns, input int nq, output logic [7:0] rd);
    int p;
    p = 39;
    rd = 8'h00;
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    repeat (16) @(posedge clk_in);
    for (int i = 0; i < ns + nq; i++) begin
      if (i < ns) begin
        io_out <= {~io_out[3:1], d[p]};
        p = p - 1;
      end else begin
        io_out <= d[p -: 4];
        p = p - 4;
      end
      repeat (8) @(posedge clk_in);
      sclk_out <= 1'b1;
      // so_in read before this edge's updates land; the bit changed three clocks after the last fall, so it has stood five of the eight
      rd = {rd[6:0], so_in};
      repeat (8) @(posedge clk_in);
      sclk_out <= 1'b0;
    end
    repeat (16) @(posedge clk_in);
    cs_n_out <= 1'b1;
    io_out <= ~io_out;
    repeat (40) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// ### bench/flash_status_reg_four_tb_top.sv
// testbench for the status register four block
`timescale 1ns/10ps
`default_nettype none
module flash_status_reg_four_tb_top;
  logic ref_clk_in = 1'b0, srst_in = 1'b1, qe = 1'b0, pf = 1'b0, ef = 1'b0, fc = 1'b0, se = 1'b0, sx = 1'b0;
  logic sclk, cs_n, ds, uds, sram, an, hrd, qs, cf, rxv;
  logic [3:0] hio, dio, doe, io_w;
  logic [7:0] rd, rxb, rx_last = 8'h00;
  int bad_count = 0, tests_run = 0, qs_cnt = 0, cf_cnt = 0, rx_cnt = 0;
  always #5 ref_clk_in = ~ref_clk_in;
  // pulse counters; scenarios compare deltas so no flag needs clearing from two places
  always @(posedge ref_clk_in) begin
    if (qs === 1'b1) qs_cnt <= qs_cnt + 1;
    if (cf === 1'b1) cf_cnt <= cf_cnt + 1;
    if (rxv === 1'b1) begin
      rx_cnt <= rx_cnt + 1;
      rx_last <= rxb;
    end
  end
  assign io_w = {hio[3:2], doe[1] ? dio[1] : hio[1], hio[0]};
  spi_host_model host_u (.clk_in(ref_clk_in), .sclk_out(sclk), .cs_n_out(cs_n), .io_out(hio), .so_in(io_w[1]));
  flash_status_reg_four dut_u (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .sclk_in(sclk), .cs_n_in(cs_n),
    .io_in(io_w), .io_out(dio), .io_oe_out(doe), .quad_line_enable_in(qe), .program_fail_in(pf),
    .erase_fail_in(ef), .fault_clear_in(fc), .seq_prog_enter_in(se), .seq_prog_exit_in(sx),
    .deep_sleep_out(ds), .ultra_deep_sleep_out(uds), .sram_retain_out(sram), .address_needed_out(an),
    .hold_reset_disabled_out(hrd), .quad_read_start_out(qs), .continuous_frame_out(cf),
    .rx_byte_out(rxb), .rx_byte_valid_out(rxv));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd_sr4(input logic [7:0] exp);
    host_u.frame({8'h15, 32'h0}, 16, 0, rd);
    chk("status", rd, exp);
  endtask
  task automatic drive(input logic [4:0] v);
    @(posedge ref_clk_in) {pf, ef, fc, se, sx} <= v;
    @(posedge ref_clk_in) {pf, ef, fc, se, sx} <= 5'h00;
    repeat (20) @(posedge ref_clk_in);
  endtask
  task automatic t_regs;
    rd_sr4(8'h01);
    host_u.frame({8'h16, 8'hFF, 24'h0}, 16, 0, rd);
    rd_sr4(8'h89);
    drive(5'b10010);
    rd_sr4(8'hE9);
    chk("addr", {7'h00, an}, 8'h00);
    drive(5'b01000);
    rd_sr4(8'hF9);
    drive(5'b10101);
    rd_sr4(8'hA9);
    host_u.frame({8'h77, 24'h0, 8'h50}, 40, 0, rd);
    rd_sr4(8'hAD);
    host_u.frame({8'h77, 24'h0, 8'hA0}, 40, 0, rd);
    rd_sr4(8'hAA);
    $display("register test done");
  endtask
  task automatic t_quad(input logic q, input logic [7:0] op);
    int q0, c0, r0;
    @(posedge ref_clk_in) qe <= q;
    host_u.frame({8'h16, 8'h08, 24'h0}, 16, 0, rd);
    q0 = qs_cnt;
    r0 = rx_cnt;
    host_u.frame({op, 32'h12345678}, 8, 8, rd);
    chk("qstart", 8'(qs_cnt - q0), 8'h01);
    chk("quadbytes", 8'(rx_cnt - r0), 8'h04);
    chk("quadlast", rx_last, 8'h78);
    chk("holdpin", {7'h00, hrd}, {7'h00, q});
    c0 = cf_cnt;
    r0 = rx_cnt;
    host_u.frame({32'h9ABCDEF0, 8'h00}, 0, 8, rd);
    chk("cmdless", 8'(cf_cnt - c0), {7'h00, q});
    chk("cmdbytes", 8'(rx_cnt - r0), q ? 8'h04 : 8'h00);
    // no mode-byte exit: dropping quad enable is the only way to disarm continuous reads
    @(posedge ref_clk_in) qe <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    $display("quad test done");
  endtask
  task automatic t_reset;
    drive(5'b00010);
    chk("seqset", {7'h00, an}, 8'h00);
    @(posedge ref_clk_in) srst_in <= 1'b1;
    repeat (10) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    chk("seqreset", {7'h00, an}, 8'h01);
    rd_sr4(8'h01);
    $display("reset test done");
  endtask
  task automatic t_sleep(input logic [7:0] depth, input logic [7:0] op, input logic [2:0] exp);
    host_u.frame({8'h16, depth, 24'h0}, 16, 0, rd);
    host_u.frame({op, 32'h0}, 8, 0, rd);
    chk("sleep", {5'h00, ds, uds, sram}, {5'h00, exp});
    host_u.frame({8'h15, 32'h0}, 16, 0, rd);
    chk("toggle", {5'h00, ds, uds, sram}, {5'h00, exp});
    host_u.frame({8'hAB, 32'h0}, 8, 0, rd);
    chk("wake", {5'h00, ds, uds, sram}, 8'h00);
    $display("sleep test done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #500000;
    bad_count++;
    stop_test;
  end
  initial begin
    repeat (10) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    t_regs;
    t_quad(1'b1, 8'hE7);
    t_quad(1'b1, 8'hEB);
    t_quad(1'b0, 8'hEB);
    t_sleep(8'h00, 8'hB9, 3'b010);
    t_sleep(8'h80, 8'hB9, 3'b101);
    t_sleep(8'h80, 8'h79, 3'b010);
    t_reset;
    stop_test;
  end
endmodule
`default_nettype wire
